// File: utt_tuning.v
// Purpose: Tuning register and start gating for IN and OUT transfers
// Assumes: aclk 20 MHz, synchronous active-low reset, AXI4-Lite slave
// Notes: Strap pin sets defaults and, when high, forces both features off
//
// Operation
// [R1] Tuning register decodes at offset 6Ch from the base.
// [R2] Software writes reserved bits 31 to 2 with their reset value.
// [R3] Bit 1 zero enables IN ring buffering, one disables.
// [R4] Ring disable bit resets to the strap pin level.
// [R5] Ring enabled: next IN packet starts once previous is received.
// [R6] Strap high makes ring disable bit read one always.
// [R7] Bit 0 zero enables OUT watermark, one disables.
// [R8] Watermark disable bit resets to the strap pin level.
// [R9] Watermark enabled: OUT starts when fetched data reaches level.
// [R10] Strap high makes watermark disable bit read one always.
// [R11] Congested bus: software should set ring disable bit.
// [R12] Congested bus: software should set watermark disable bit.
// [R13] Feature active only with strap low and disable bit zero.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "utt_consts.vh"

module utt_tuning (
    input wire aclk,
    input wire aresetn,
    input wire tuning_strap_pin,
    input wire [`UTT_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`UTT_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire in_pkt_done,
    input wire in_drained,
    input wire [`UTT_SIZE_W-1:0] out_fetched,
    input wire out_fetch_full,
    output reg in_start,
    output reg out_start,
    output reg ring_active,
    output reg out_threshold_active
);

    reg ring_buffer_off_q;
    reg out_threshold_off_q;
    reg rst_seen_q;
    reg [`UTT_SIZE_W-1:0] pkt_size_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [`UTT_ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg in_wait_q;
    reg out_sent_q;
    reg b_pend_q;
    wire [`UTT_SIZE_W-1:0] level;
    wire aw_have;
    wire w_have;
    wire do_write;
    wire [`UTT_ADDR_W-1:0] wa;
    wire [31:0] wd;
    wire [3:0] ws;
    wire ring_en;
    wire wm_en;

    function known_addr;
        input [`UTT_ADDR_W-1:0] a;
        begin
            known_addr = (a == `UTT_OFS_TUNING) || (a == `UTT_OFS_STATUS)
                || (a == `UTT_OFS_PKTSIZE);
        end
    endfunction

    // [R13] Effective enables
    assign ring_en = ~tuning_strap_pin & ~ring_buffer_off_q;
    assign wm_en = ~tuning_strap_pin & ~out_threshold_off_q;

    utt_wmark u_wmark (
        .pkt_size(pkt_size_q),
        .level(level)
    );

    assign aw_have = aw_hold_q | s_axi_awvalid;
    assign w_have = w_hold_q | s_axi_wvalid;
    assign do_write = aw_have & w_have & ~s_axi_bvalid & ~b_pend_q;
    assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    assign wd = w_hold_q ? wdata_q : s_axi_wdata;
    assign ws = w_hold_q ? wstrb_q : s_axi_wstrb;

    // Write channel capture, either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= {`UTT_ADDR_W{1'b0}};
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UTT_RESP_OKAY;
            b_pend_q <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid & ~aw_hold_q & ~s_axi_awready & ~do_write) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid & ~w_hold_q & ~s_axi_wready & ~do_write) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            if (do_write & ~s_axi_awready & ~s_axi_wready) begin
                s_axi_awready <= ~aw_hold_q;
                s_axi_wready <= ~w_hold_q;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                // Response only after both channels are taken
                b_pend_q <= 1'b1;
                // [R1] Decode at 6Ch
                s_axi_bresp <= known_addr(wa) ? `UTT_RESP_OKAY : `UTT_RESP_SLVERR;
            end else if (b_pend_q) begin
                b_pend_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wr_fire;
    assign wr_fire = do_write & ~s_axi_awready & ~s_axi_wready;

    // Register state and strap capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            ring_buffer_off_q <= 1'b0;
            out_threshold_off_q <= 1'b0;
            rst_seen_q <= 1'b1;
            pkt_size_q <= `UTT_DEF_PKTSIZE;
        end else begin
            rst_seen_q <= 1'b0;
            if (rst_seen_q) begin
                // [R4] Ring default from strap
                ring_buffer_off_q <= tuning_strap_pin;
                // [R8] Watermark default from strap
                out_threshold_off_q <= tuning_strap_pin;
            end else if (wr_fire && wa == `UTT_OFS_TUNING && ws[0]) begin
                // [R3] Ring disable bit
                ring_buffer_off_q <= wd[`UTT_BIT_RING_OFF];
                // [R7] Watermark disable bit
                out_threshold_off_q <= wd[`UTT_BIT_OUT_OFF];
            end
            if (wr_fire && wa == `UTT_OFS_PKTSIZE && ws[0] && ws[1]) begin
                pkt_size_q <= wd[`UTT_SIZE_W-1:0];
            end
        end
    end

    // Read channel, one cycle answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `UTT_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known_addr(s_axi_araddr) ? `UTT_RESP_OKAY
                    : `UTT_RESP_SLVERR;
                case (s_axi_araddr)
                    // [R6] [R10] Strap high reads one
                    `UTT_OFS_TUNING: s_axi_rdata <= {30'h0,
                        ring_buffer_off_q | tuning_strap_pin,
                        out_threshold_off_q | tuning_strap_pin};
                    `UTT_OFS_STATUS: s_axi_rdata <= {28'h0, in_wait_q,
                        out_sent_q, ring_en, wm_en};
                    `UTT_OFS_PKTSIZE: s_axi_rdata <= {21'h0, pkt_size_q};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Transfer start gating
    always @(posedge aclk) begin
        if (!aresetn) begin
            in_wait_q <= 1'b0;
            out_sent_q <= 1'b0;
            in_start <= 1'b0;
            out_start <= 1'b0;
            ring_active <= 1'b0;
            out_threshold_active <= 1'b0;
        end else begin
            ring_active <= ring_en;
            out_threshold_active <= wm_en;
            in_start <= 1'b0;
            out_start <= 1'b0;
            // [R5] Next IN starts without drain
            if (in_pkt_done & ring_en) begin
                in_start <= 1'b1;
                in_wait_q <= 1'b0;
            end else if (in_pkt_done) begin
                in_wait_q <= 1'b1;
            end else if (in_wait_q & (in_drained | ring_en)) begin
                in_start <= 1'b1;
                in_wait_q <= 1'b0;
            end
            // [R9] OUT starts at watermark
            if (out_fetched == {`UTT_SIZE_W{1'b0}}) begin
                out_sent_q <= 1'b0;
            end else if (~out_sent_q & ((wm_en & out_fetched >= level)
                    | out_fetch_full)) begin
                out_start <= 1'b1;
                out_sent_q <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// File: utt_consts.vh
// Purpose: Constants for the USB transfer tuning control block
// Assumes: AXI4-Lite slave, 32-bit data, byte addresses
// Notes: Extra status and packet size registers sit beside the tuning word
`ifndef UTT_CONSTS_VH
`define UTT_CONSTS_VH

`define UTT_ADDR_W 8
`define UTT_OFS_TUNING 8'h6c
`define UTT_OFS_STATUS 8'h70
`define UTT_OFS_PKTSIZE 8'h74
`define UTT_BIT_OUT_OFF 0
`define UTT_BIT_RING_OFF 1
`define UTT_RESP_OKAY 2'h0
`define UTT_RESP_SLVERR 2'h2
`define UTT_SIZE_W 11
`define UTT_DEF_PKTSIZE 11'h400

`endif

// File: utt_wmark.v
// Purpose: Watermark level lookup for OUT packet start
// Assumes: Packet size in bytes, up to 1024
// Notes: Picks one less than the largest step below the packet size, or the size itself up to C0h
`timescale 1ns/10ps
`default_nettype none
`include "utt_consts.vh"

module utt_wmark (
    input wire [`UTT_SIZE_W-1:0] pkt_size,
    output reg [`UTT_SIZE_W-1:0] level
);

    always @* begin
        if (pkt_size > 11'h300) begin
            level = 11'h2ff;
        end else if (pkt_size > 11'h280) begin
            level = 11'h27f;
        end else if (pkt_size > 11'h200) begin
            level = 11'h1ff;
        end else if (pkt_size > 11'h180) begin
            level = 11'h17f;
        end else if (pkt_size > 11'h100) begin
            level = 11'h0ff;
        end else if (pkt_size > 11'h0c0) begin
            level = 11'h0bf;
        end else begin
            level = pkt_size;
        end
    end

endmodule
`default_nettype wire

// File: utt_usb_model.sv
// Purpose: USB side model that fetches OUT packet data byte by byte
// Assumes: One byte fetched per cycle, packet of the default size
// Notes: Records the fetched count seen at the OUT start pulse
`timescale 1ns/10ps
`default_nettype none
`include "utt_consts.vh"
module utt_usb_model (
    input wire logic aclk,
    input wire logic run,
    input wire logic out_start,
    output logic [`UTT_SIZE_W-1:0] out_fetched = '0,
    output logic out_fetch_full,
    output logic [`UTT_SIZE_W-1:0] start_at = '0
);
    assign out_fetch_full = (out_fetched == `UTT_DEF_PKTSIZE);
    always @(posedge aclk) begin
        if (!run) begin
            out_fetched <= '0;
            start_at <= '0;
        end else if (!out_fetch_full) begin
            out_fetched <= out_fetched + 11'h1;
        end
        if (out_start) begin
            start_at <= out_fetched;
        end
    end
endmodule
`default_nettype wire

// File: utt_tuning_chk.sv
// Purpose: Port checker for the tuning register block
// Assumes: Single clock, synchronous active-low reset
// Notes: Strap held steady between resets
`timescale 1ns/10ps
`default_nettype none
module utt_tuning_chk (
    input wire aclk,
    input wire aresetn,
    input wire tuning_strap_pin,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire in_pkt_done,
    input wire in_drained,
    input wire in_start,
    input wire out_start,
    input wire ring_active,
    input wire out_threshold_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ring_strap: assert property (tuning_strap_pin |-> !ring_active)
        else $error("ring on with strap high");
    a_out_strap: assert property (tuning_strap_pin |-> !out_threshold_active)
        else $error("watermark on with strap high");
    a_ring_start: assert property (in_pkt_done && ring_active |=> in_start)
        else $error("no prompt IN start");
    a_in_cause: assert property (in_start |-> $past(in_pkt_done) || $past(in_drained))
        else $error("IN start without cause");
    a_out_once: assert property (out_start |=> !out_start)
        else $error("OUT start repeated");
    a_rd_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("late read answer");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready held");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held after take");
    c_in: cover property (in_start);
    c_out: cover property (out_start);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind utt_tuning utt_tuning_chk u_utt_tuning_chk (.aclk, .aresetn, .tuning_strap_pin,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready,
    .in_pkt_done, .in_drained, .in_start, .out_start, .ring_active, .out_threshold_active);
`default_nettype wire

// File: tb_usb_transfer_tuning_ctrl.sv
// Purpose: Self-checking bench for the tuning register block
// Assumes: AXI4-Lite master tasks, 50 ns clock
// Notes: Strap changed only while reset is held
`timescale 1ns/10ps
`default_nettype none
`include "utt_consts.vh"
module tb_usb_transfer_tuning_ctrl;
    logic aclk = '0, aresetn = '0, tuning_strap_pin = '0, in_pkt_done = '0, in_drained = '0;
    logic run = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, in_start, out_start, ring_active, out_threshold_active;
    logic out_fetch_full;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
    logic [10:0] out_fetched, start_at;
    int num_errors = 0, tests_run = 0;
    always #25 aclk = ~aclk;
    utt_tuning u_utt_tuning (.aclk, .aresetn, .tuning_strap_pin, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_pkt_done,
        .in_drained, .out_fetched, .out_fetch_full, .in_start, .out_start, .ring_active,
        .out_threshold_active);
    utt_usb_model u_utt_usb_model (.aclk, .run, .out_start, .out_fetched, .out_fetch_full,
        .start_at);
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %0t seen %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        bs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask
    task rst(input logic s);
        aresetn <= 1'h0;
        tuning_strap_pin <= s;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
    endtask
    task t_bits();
        rdr(`UTT_OFS_TUNING);
        chk(rd, 32'h0);
        chk({ring_active, out_threshold_active}, 2'h3);
        // Reserved bits kept zero, watermark disable bit set, then ring disable bit
        wr(`UTT_OFS_TUNING, 32'h1);
        chk(bs, `UTT_RESP_OKAY);
        rdr(`UTT_OFS_TUNING);
        chk(rd, 32'h1);
        chk({ring_active, out_threshold_active}, 2'h2);
        wr(`UTT_OFS_TUNING, 32'h2);
        rdr(`UTT_OFS_TUNING);
        chk(rd, 32'h2);
        chk({ring_active, out_threshold_active}, 2'h1);
        // No byte 0 strobe leaves both bits alone
        s_axi_wstrb <= 4'h0;
        wr(`UTT_OFS_TUNING, 32'h1);
        s_axi_wstrb <= 4'hf;
        rdr(`UTT_OFS_TUNING);
        chk(rd, 32'h2);
        rdr(8'h40);
        chk(rs, `UTT_RESP_SLVERR);
        chk(rd, 32'h0);
        wr(8'h40, 32'h0);
        chk(bs, `UTT_RESP_SLVERR);
    endtask
    task t_in(input logic ring);
        wr(`UTT_OFS_TUNING, {30'h0, ~ring, 1'h0});
        @(posedge aclk) in_pkt_done <= 1'h1;
        @(posedge aclk) in_pkt_done <= 1'h0;
        #1 chk(in_start, ring);
        rdr(`UTT_OFS_STATUS);
        chk(rd, {28'h0, ~ring, 1'h0, ring, 1'h1});
        @(posedge aclk) in_drained <= 1'h1;
        @(posedge aclk) in_drained <= 1'h0;
        #1 chk(in_start, {31'h0, ~ring});
    endtask
    task t_out(input logic off, input logic [10:0] e);
        wr(`UTT_OFS_TUNING, {31'h0, off});
        @(posedge aclk) run <= 1'h1;
        repeat (1100) @(posedge aclk);
        chk(start_at, e);
        run <= 1'h0;
    endtask
    task t_strap();
        rst(1'h1);
        rdr(`UTT_OFS_TUNING);
        chk(rd, 32'h3);
        wr(`UTT_OFS_TUNING, 32'h0);
        rdr(`UTT_OFS_TUNING);
        chk(rd, 32'h3);
        chk({ring_active, out_threshold_active}, 2'h0);
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(8000 * 50);
        num_errors++;
        summarize();
    end
    initial begin
        rst(1'h0);
        t_bits();
        t_in(1'h1);
        t_in(1'h0);
        t_out(1'h0, 11'h300);
        t_out(1'h1, `UTT_DEF_PKTSIZE);
        wr(`UTT_OFS_PKTSIZE, 32'h200);
        rdr(`UTT_OFS_PKTSIZE);
        chk(rd, 32'h200);
        t_out(1'h0, 11'h180);
        t_strap();
        summarize();
    end
endmodule
`default_nettype wire
